// >>> rsc_ramp_seq.sv
// The AXI4-Lite register port was left to the implementer.
module rsc_ramp_seq (
   input  wire logic              clk,
   input  wire logic              rst,
   input  wire logic [11:0]       awaddr,
   input  wire logic              awvalid,
   output      logic              awready,
   input  wire logic [31:0]       wdata,
   input  wire logic [3:0]        wstrb,
   input  wire logic              wvalid,
   output      logic              wready,
   output      logic [1:0]        bresp,
   output      logic              bvalid,
   input  wire logic              bready,
   input  wire logic [11:0]       araddr,
   input  wire logic              arvalid,
   output      logic              arready,
   output      logic [31:0]       rdata,
   output      logic [1:0]        rresp,
   output      logic              rvalid,
   input  wire logic              rready,
   input  wire logic              rampClockPin,
   input  wire logic              rampDirectionPin,
   input  wire logic [1:0]        tuneLockStatus,
   input  wire logic              calDone,
   input  wire rsc_pkg::rsc_cal_t calResult,
   output      logic              calStart,
   output rsc_pkg::rsc_state_t    rampState,
   output      logic              manualMode,
   output      logic [15:0]       doublerBiasSetting
);
   // writable configuration
   logic [15:0]         dblr_reg;
   logic [3:0]          trigA_reg;
   logic [3:0]          trigB_reg;
   logic [15:0]         len0_reg;
   logic [15:0]         len1_reg;
   logic [9:0]          calDelayCount_reg;
   logic                successor_reg;
   logic [1:0]          advSource_reg;
   logic                postCal_reg;
   logic [2:0]          scale_reg;
   logic                rampEnable_reg;
   // readback
   logic [1:0]          lock_reg;
   rsc_pkg::rsc_cal_t   chosen_reg;
   // bus holding state
   logic [9:0]          wrIdx_reg;
   logic [31:0]         wrData_reg;
   logic [3:0]          wrStrb_reg;
   // sequencer
   rsc_pkg::rsc_state_t state_reg;
   rsc_pkg::rsc_state_t state_next;
   rsc_pkg::rsc_state_t target_reg;
   rsc_pkg::rsc_state_t target_next;
   logic [15:0]         lenCnt_reg;
   logic [16:0]         delay_reg;
   logic                calSeen_reg;
   logic                clkPrev_reg;
   logic                dirPrev_reg;
   logic                trigA;
   logic                trigB;
   logic                advance;
   logic                rampDone;
   logic                wrCommit;
   logic [31:0]         rdWord;
   logic                rdErr;

   function automatic logic trigHit(input logic [3:0] code, input logic ck, input logic ckP,
                                    input logic dr, input logic drP);
      unique case (code)
         rsc_pkg::RSC_TRG_CLK_RISE: trigHit = ck & ~ckP;
         rsc_pkg::RSC_TRG_DIR_RISE: trigHit = dr & ~drP;
         rsc_pkg::RSC_TRG_ALWAYS:   trigHit = 1'b1;
         rsc_pkg::RSC_TRG_CLK_FALL: trigHit = ~ck & ckP;
         rsc_pkg::RSC_TRG_DIR_FALL: trigHit = ~dr & drP;
         default:                   trigHit = 1'b0;
      endcase
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   // ---------------- write channel ----------------
   // address and data are taken independently; the write lands once both are held
   assign wrCommit = ~awready & ~wready & ~bvalid;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         awready   <= 1'b1;
         wready    <= 1'b1;
         bvalid    <= 1'b0;
         bresp     <= rsc_pkg::RSC_RESP_OKAY;
         wrIdx_reg <= 10'h000;
         wrData_reg <= 32'h0000_0000;
         wrStrb_reg <= 4'h0;
      end else begin
         if (awvalid && awready) begin
            awready   <= 1'b0;
            wrIdx_reg <= awaddr[11:2];
         end
         if (wvalid && wready) begin
            wready     <= 1'b0;
            wrData_reg <= wdata;
            wrStrb_reg <= wstrb;
         end
         if (wrCommit) begin
            bvalid <= 1'b1;
            unique case (wrIdx_reg)
               rsc_pkg::RSC_IDX_DBLR, rsc_pkg::RSC_IDX_TRIG, rsc_pkg::RSC_IDX_LEN0,
               rsc_pkg::RSC_IDX_LEN1, rsc_pkg::RSC_IDX_SEQ, rsc_pkg::RSC_IDX_SCALE,
               rsc_pkg::RSC_IDX_CTRL, rsc_pkg::RSC_IDX_LOCK, rsc_pkg::RSC_IDX_CAP,
               rsc_pkg::RSC_IDX_AMP: bresp <= rsc_pkg::RSC_RESP_OKAY;
               default:              bresp <= rsc_pkg::RSC_RESP_SLVERR;
            endcase
         end
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   // read-only indices fall through: the write is acknowledged but changes nothing
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         dblr_reg          <= rsc_pkg::RSC_DBLR_RST;
         trigA_reg         <= rsc_pkg::RSC_TRG_OFF;
         trigB_reg         <= rsc_pkg::RSC_TRG_OFF;
         len0_reg          <= 16'h0000;
         len1_reg          <= 16'h0000;
         calDelayCount_reg <= 10'h000;
         manualMode        <= 1'b0;
         successor_reg     <= 1'b0;
         advSource_reg     <= rsc_pkg::RSC_ADV_LEN;
         postCal_reg       <= 1'b0;
         scale_reg         <= rsc_pkg::RSC_SCALE_RST;
         rampEnable_reg    <= 1'b0;
      end else if (wrCommit) begin
         unique case (wrIdx_reg)
            rsc_pkg::RSC_IDX_DBLR: dblr_reg <= merge(dblr_reg, wrData_reg, wrStrb_reg);
            rsc_pkg::RSC_IDX_TRIG: begin
               if (wrStrb_reg[0]) begin
                  trigA_reg <= wrData_reg[rsc_pkg::RSC_TRIGA_LSB +: 4];
               end
               // trigger B straddles both low byte lanes, so it lands only when both are strobed
               if (wrStrb_reg[0] && wrStrb_reg[1]) begin
                  trigB_reg <= wrData_reg[rsc_pkg::RSC_TRIGB_LSB +: 4];
               end
            end
            rsc_pkg::RSC_IDX_LEN0: len0_reg <= merge(len0_reg, wrData_reg, wrStrb_reg);
            rsc_pkg::RSC_IDX_LEN1: len1_reg <= merge(len1_reg, wrData_reg, wrStrb_reg);
            rsc_pkg::RSC_IDX_SEQ: begin
               if (wrStrb_reg[0]) begin
                  manualMode    <= wrData_reg[rsc_pkg::RSC_MANUAL_BIT];
                  successor_reg <= wrData_reg[rsc_pkg::RSC_SUCC_BIT];
                  advSource_reg <= wrData_reg[1:0];
               end
               if (wrStrb_reg[0] && wrStrb_reg[1]) begin
                  calDelayCount_reg <= wrData_reg[rsc_pkg::RSC_DLY_LSB +: 10];
               end
            end
            rsc_pkg::RSC_IDX_SCALE: begin
               if (wrStrb_reg[0]) begin
                  postCal_reg <= wrData_reg[rsc_pkg::RSC_CAL_BIT];
                  scale_reg   <= wrData_reg[2:0];
               end
            end
            rsc_pkg::RSC_IDX_CTRL: begin
               if (wrStrb_reg[0]) begin
                  rampEnable_reg <= wrData_reg[0];
               end
            end
            default: ;
         endcase
      end
   end

   assign doublerBiasSetting = dblr_reg;

   // ---------------- read channel ----------------
   always_comb begin
      rdWord = 32'h0000_0000;
      rdErr  = 1'b0;
      unique case (araddr[11:2])
         rsc_pkg::RSC_IDX_DBLR:  rdWord[15:0] = dblr_reg;
         rsc_pkg::RSC_IDX_TRIG: begin
            rdWord[rsc_pkg::RSC_TRIGA_LSB +: 4] = trigA_reg;
            rdWord[rsc_pkg::RSC_TRIGB_LSB +: 4] = trigB_reg;
         end
         rsc_pkg::RSC_IDX_LEN0:  rdWord[15:0] = len0_reg;
         rsc_pkg::RSC_IDX_LEN1:  rdWord[15:0] = len1_reg;
         rsc_pkg::RSC_IDX_SEQ: begin
            rdWord[rsc_pkg::RSC_DLY_LSB +: 10]  = calDelayCount_reg;
            rdWord[rsc_pkg::RSC_MANUAL_BIT]     = manualMode;
            rdWord[rsc_pkg::RSC_SUCC_BIT]       = successor_reg;
            rdWord[1:0]                         = advSource_reg;
         end
         rsc_pkg::RSC_IDX_SCALE: begin
            rdWord[rsc_pkg::RSC_CAL_BIT] = postCal_reg;
            rdWord[2:0]                  = scale_reg;
         end
         rsc_pkg::RSC_IDX_LOCK: begin
            rdWord[rsc_pkg::RSC_LOCK_LSB +: 2] = lock_reg;
            rdWord[rsc_pkg::RSC_CORE_LSB +: 3] = chosen_reg.core;
         end
         rsc_pkg::RSC_IDX_CAP:   rdWord[7:0] = chosen_reg.cap;
         rsc_pkg::RSC_IDX_AMP:   rdWord[8:0] = chosen_reg.amp;
         rsc_pkg::RSC_IDX_CTRL: begin
            rdWord[0]   = rampEnable_reg;
            rdWord[9:8] = state_reg;
         end
         default:                rdErr = 1'b1;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= rsc_pkg::RSC_RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= rdWord;
         rresp   <= rdErr ? rsc_pkg::RSC_RESP_SLVERR : rsc_pkg::RSC_RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   // ---------------- readback capture ----------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_reg        <= rsc_pkg::RSC_LOCK_RST;
         chosen_reg.core <= rsc_pkg::RSC_CORE_RST;
         chosen_reg.cap  <= rsc_pkg::RSC_CAP_RST;
         chosen_reg.amp  <= rsc_pkg::RSC_AMP_RST;
      end else begin
         lock_reg <= tuneLockStatus;
         if (calDone) begin
            chosen_reg <= calResult;
         end
      end
   end

   // ---------------- triggers ----------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         clkPrev_reg <= 1'b0;
         dirPrev_reg <= 1'b0;
      end else begin
         clkPrev_reg <= rampClockPin;
         dirPrev_reg <= rampDirectionPin;
      end
   end

   assign trigA = trigHit(trigA_reg, rampClockPin, clkPrev_reg, rampDirectionPin, dirPrev_reg);
   assign trigB = trigHit(trigB_reg, rampClockPin, clkPrev_reg, rampDirectionPin, dirPrev_reg);

   // reserved source never advances, so the second ramp holds until reconfigured
   always_comb begin
      unique case (advSource_reg)
         rsc_pkg::RSC_ADV_LEN: advance = (lenCnt_reg == len1_reg);
         rsc_pkg::RSC_ADV_A:   advance = trigA;
         rsc_pkg::RSC_ADV_B:   advance = trigB;
         rsc_pkg::RSC_ADV_RSV: advance = 1'b0;
      endcase
   end

   // ---------------- sequencer ----------------
   always_comb begin
      state_next  = state_reg;
      target_next = target_reg;
      rampDone    = 1'b0;
      unique case (state_reg)
         rsc_pkg::RSC_IDLE: if (rampEnable_reg) state_next = rsc_pkg::RSC_FIRST;
         rsc_pkg::RSC_FIRST: begin
            if (lenCnt_reg == len0_reg) begin
               rampDone    = 1'b1;
               target_next = rsc_pkg::RSC_SECOND;
            end
         end
         rsc_pkg::RSC_SECOND: begin
            if (advance) begin
               rampDone    = 1'b1;
               target_next = successor_reg ? rsc_pkg::RSC_SECOND : rsc_pkg::RSC_FIRST;
            end
         end
         rsc_pkg::RSC_CAL: begin
            if (delay_reg == 17'h0_0000 && calSeen_reg) state_next = target_reg;
         end
      endcase
      if (rampDone) begin
         state_next = postCal_reg ? rsc_pkg::RSC_CAL : target_next;
      end
      if (!rampEnable_reg) begin
         state_next = rsc_pkg::RSC_IDLE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg  <= rsc_pkg::RSC_IDLE;
         target_reg <= rsc_pkg::RSC_FIRST;
         lenCnt_reg <= 16'h0000;
      end else begin
         state_reg  <= state_next;
         target_reg <= target_next;
         // length counter restarts on every ramp entry, including a repeat of the same ramp
         if (rampDone || state_reg != state_next) lenCnt_reg <= 16'h0000;
         else lenCnt_reg <= lenCnt_reg + 16'h0001;
      end
   end

   assign rampState = state_reg;

   // calibration pacing: the delay floor and the real completion must both be met
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         calStart    <= 1'b0;
         delay_reg   <= 17'h0_0000;
         calSeen_reg <= 1'b0;
      end else begin
         calStart <= rampDone && postCal_reg && rampEnable_reg;
         if (rampDone && postCal_reg) begin
            delay_reg   <= 17'({7'h00, calDelayCount_reg} << scale_reg);
            calSeen_reg <= 1'b0;
         end else begin
            if (delay_reg != 17'h0_0000) delay_reg <= delay_reg - 17'h0_0001;
            if (calDone) calSeen_reg <= 1'b1;
         end
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   property p_successor;
      state_reg == rsc_pkg::RSC_SECOND && advance && !postCal_reg && rampEnable_reg
         |=> state_reg == (successor_reg ? rsc_pkg::RSC_SECOND : rsc_pkg::RSC_FIRST);
   endproperty
   a_successor: assert property (p_successor) else $error("wrong ramp after second ramp");

   property p_reserved;
      advSource_reg == rsc_pkg::RSC_ADV_RSV && state_reg == rsc_pkg::RSC_SECOND && rampEnable_reg
         |=> state_reg == rsc_pkg::RSC_SECOND;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved source advanced");

   property p_lenAdvance;
      state_reg == rsc_pkg::RSC_SECOND && advSource_reg == rsc_pkg::RSC_ADV_LEN
         && lenCnt_reg == len1_reg |-> rampDone;
   endproperty
   a_lenAdvance: assert property (p_lenAdvance) else $error("length expiry ignored");

   property p_calLaunch;
      rampDone && postCal_reg && rampEnable_reg |=> calStart && state_reg == rsc_pkg::RSC_CAL;
   endproperty
   a_calLaunch: assert property (p_calLaunch) else $error("calibration not launched");

   property p_calFloor;
      $rose(calStart) |-> delay_reg == 17'({7'h00, $past(calDelayCount_reg)} << $past(scale_reg));
   endproperty
   a_calFloor: assert property (p_calFloor) else $error("scaled delay wrong");

   property p_calWait;
      state_reg == rsc_pkg::RSC_CAL && rampEnable_reg && (delay_reg != 17'h0_0000 || !calSeen_reg)
         |=> state_reg == rsc_pkg::RSC_CAL;
   endproperty
   a_calWait: assert property (p_calWait) else $error("left calibration early");

   property p_lock;
      ##1 lock_reg == $past(tuneLockStatus);
   endproperty
   a_lock: assert property (p_lock) else $error("lock readback stale");

   property p_chosen;
      calDone |=> chosen_reg == $past(calResult);
   endproperty
   a_chosen: assert property (p_chosen) else $error("calibration result not captured");

   property p_roIgnored;
      wrCommit && !calDone && (wrIdx_reg == rsc_pkg::RSC_IDX_CAP || wrIdx_reg == rsc_pkg::RSC_IDX_AMP)
         |=> $stable(chosen_reg);
   endproperty
   a_roIgnored: assert property (p_roIgnored) else $error("read-only register written");

   property p_trigAlways;
      trigA_reg == rsc_pkg::RSC_TRG_ALWAYS |-> trigA;
   endproperty
   a_trigAlways: assert property (p_trigAlways) else $error("always trigger missing");
endmodule

// >>> rsc_pkg.sv
package rsc_pkg;
   // register indices; byte address is four times the index
   localparam logic [9:0] RSC_IDX_DBLR  = 10'h019;
   localparam logic [9:0] RSC_IDX_TRIG  = 10'h061;
   localparam logic [9:0] RSC_IDX_LEN0  = 10'h064;
   localparam logic [9:0] RSC_IDX_LEN1  = 10'h068;
   localparam logic [9:0] RSC_IDX_SEQ   = 10'h069;
   localparam logic [9:0] RSC_IDX_SCALE = 10'h06a;
   localparam logic [9:0] RSC_IDX_LOCK  = 10'h06e;
   localparam logic [9:0] RSC_IDX_CAP   = 10'h06f;
   localparam logic [9:0] RSC_IDX_AMP   = 10'h070;
   localparam logic [9:0] RSC_IDX_CTRL  = 10'h080;

   // field positions
   localparam int RSC_TRIGA_LSB  = 3;
   localparam int RSC_TRIGB_LSB  = 7;
   localparam int RSC_DLY_LSB    = 6;
   localparam int RSC_MANUAL_BIT = 5;
   localparam int RSC_SUCC_BIT   = 4;
   localparam int RSC_CAL_BIT    = 4;
   localparam int RSC_LOCK_LSB   = 9;
   localparam int RSC_CORE_LSB   = 5;

   // reset values
   localparam logic [15:0] RSC_DBLR_RST  = 16'h0000;
   localparam logic [2:0]  RSC_SCALE_RST = 3'h7;
   localparam logic [1:0]  RSC_LOCK_RST  = 2'h0;
   localparam logic [2:0]  RSC_CORE_RST  = 3'h0;
   localparam logic [7:0]  RSC_CAP_RST   = 8'hb7;
   localparam logic [8:0]  RSC_AMP_RST   = 9'h0aa;

   // trigger source codes
   localparam logic [3:0] RSC_TRG_OFF      = 4'h0;
   localparam logic [3:0] RSC_TRG_CLK_RISE = 4'h1;
   localparam logic [3:0] RSC_TRG_DIR_RISE = 4'h2;
   localparam logic [3:0] RSC_TRG_ALWAYS   = 4'h4;
   localparam logic [3:0] RSC_TRG_CLK_FALL = 4'h9;
   localparam logic [3:0] RSC_TRG_DIR_FALL = 4'ha;

   // second ramp advance sources
   localparam logic [1:0] RSC_ADV_LEN = 2'h0;
   localparam logic [1:0] RSC_ADV_A   = 2'h1;
   localparam logic [1:0] RSC_ADV_B   = 2'h2;
   localparam logic [1:0] RSC_ADV_RSV = 2'h3;

   localparam logic [1:0] RSC_RESP_OKAY   = 2'h0;
   localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      RSC_IDLE   = 2'h0,
      RSC_FIRST  = 2'h1,
      RSC_SECOND = 2'h2,
      RSC_CAL    = 2'h3
   } rsc_state_t;

   typedef struct packed {
      logic [2:0] core;
      logic [7:0] cap;
      logic [8:0] amp;
   } rsc_cal_t;
endpackage

// >>> rsc_host_model.sv
module rsc_host_model (
   input  wire logic        clk,
   output      logic [11:0] awaddr,
   output      logic        awvalid,
   input  wire logic        awready,
   output      logic [31:0] wdata,
   output      logic [3:0]  wstrb,
   output      logic        wvalid,
   input  wire logic        wready,
   input  wire logic [1:0]  bresp,
   input  wire logic        bvalid,
   output      logic        bready,
   output      logic [11:0] araddr,
   output      logic        arvalid,
   input  wire logic        arready,
   input  wire logic [31:0] rdata,
   input  wire logic [1:0]  rresp,
   input  wire logic        rvalid,
   output      logic        rready
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end

   // address and data offered together, each released once taken
   task automatic wr(input logic [11:0] a, input logic [15:0] d, output logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'b0;
      w = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= {16'h0000, d};
      wstrb <= 4'h3;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awvalid && awready) begin
            aw = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end while (!(aw && w));
      while (bvalid !== 1'b1) @(posedge clk);
      r = bresp;
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk); while (!arready);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1) @(posedge clk);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask
endmodule

// >>> ramp_sequence_and_cal_readback_tb_top.sv
module ramp_sequence_and_cal_readback_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, rampClockPin, rampDirectionPin, calDone, calStart, manualMode;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp, tuneLockStatus;
   logic [15:0] doublerBiasSetting;
   rsc_pkg::rsc_cal_t calResult;
   rsc_pkg::rsc_state_t rampState;
   int bad_count = 0;
   int check_count = 0;
   int calCount = 0;

   rsc_ramp_seq u_dut (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .rampClockPin(rampClockPin),
      .rampDirectionPin(rampDirectionPin), .tuneLockStatus(tuneLockStatus), .calDone(calDone),
      .calResult(calResult), .calStart(calStart), .rampState(rampState), .manualMode(manualMode),
      .doublerBiasSetting(doublerBiasSetting));

   rsc_host_model u_host (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // calibration engine answers one cycle after launch
   always @(posedge clk) begin
      calDone <= calStart;
      if (calStart === 1'b1) calCount <= calCount + 1;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wreg(input logic [9:0] i, input logic [15:0] d, input logic [1:0] er);
      logic [1:0] r;
      u_host.wr({i, 2'b00}, d, r);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic rreg(input logic [9:0] i, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0] r;
      u_host.rd({i, 2'b00}, d, r);
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask

   task automatic wait_state(input rsc_pkg::rsc_state_t s);
      int n;
      n = 0;
      // look just after each edge so one-cycle pulses launched with the state are still standing
      while (n < 60 && rampState !== s) begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({30'h0, rampState}, {30'h0, s});
   endtask

   task automatic test_reset_and_ro;
      chk({16'h0, doublerBiasSetting}, 32'h0000_0000);
      rreg(rsc_pkg::RSC_IDX_LOCK, 32'h0000_0000, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_CAP, 32'h0000_00b7, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_AMP, 32'h0000_00aa, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_SCALE, 32'h0000_0007, rsc_pkg::RSC_RESP_OKAY);
      wreg(rsc_pkg::RSC_IDX_CAP, 16'hffff, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_CAP, 32'h0000_00b7, rsc_pkg::RSC_RESP_OKAY);
      wreg(10'h3ff, 16'h1234, rsc_pkg::RSC_RESP_SLVERR);
      rreg(10'h3ff, 32'h0000_0000, rsc_pkg::RSC_RESP_SLVERR);
      wreg(rsc_pkg::RSC_IDX_DBLR, 16'h0c2b, rsc_pkg::RSC_RESP_OKAY);
      chk({16'h0, doublerBiasSetting}, 32'h0000_0c2b);
      $display("test reset and read-only done");
   endtask

   task automatic test_cal_after_ramp;
      wreg(rsc_pkg::RSC_IDX_LEN0, 16'h0002, rsc_pkg::RSC_RESP_OKAY);
      wreg(rsc_pkg::RSC_IDX_LEN1, 16'h0001, rsc_pkg::RSC_RESP_OKAY);
      // delay count 2, length expiry, back to first ramp
      wreg(rsc_pkg::RSC_IDX_SEQ, 16'h0080, rsc_pkg::RSC_RESP_OKAY);
      wreg(rsc_pkg::RSC_IDX_SCALE, 16'h0010, rsc_pkg::RSC_RESP_OKAY);
      wreg(rsc_pkg::RSC_IDX_CTRL, 16'h0001, rsc_pkg::RSC_RESP_OKAY);
      wait_state(rsc_pkg::RSC_CAL);
      chk({31'h0, calStart}, 32'h0000_0001);
      wait_state(rsc_pkg::RSC_FIRST);
      wreg(rsc_pkg::RSC_IDX_CTRL, 16'h0000, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_LOCK, 32'h0000_0460, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_CAP, 32'h0000_005a, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_AMP, 32'h0000_0123, rsc_pkg::RSC_RESP_OKAY);
      $display("test calibration after ramp done");
   endtask

   task automatic test_trigger_a;
      int c0;
      c0 = calCount;
      wreg(rsc_pkg::RSC_IDX_SCALE, 16'h0000, rsc_pkg::RSC_RESP_OKAY);
      wreg(rsc_pkg::RSC_IDX_SEQ, 16'h0001, rsc_pkg::RSC_RESP_OKAY);
      wreg(rsc_pkg::RSC_IDX_TRIG, 16'h0008, rsc_pkg::RSC_RESP_OKAY);
      wreg(rsc_pkg::RSC_IDX_CTRL, 16'h0001, rsc_pkg::RSC_RESP_OKAY);
      wait_state(rsc_pkg::RSC_SECOND);
      repeat (10) @(posedge clk);
      #1 chk({30'h0, rampState}, {30'h0, rsc_pkg::RSC_SECOND});
      @(posedge clk) rampClockPin <= 1'b1;
      wait_state(rsc_pkg::RSC_FIRST);
      chk(calCount, c0);
      wreg(rsc_pkg::RSC_IDX_CTRL, 16'h0000, rsc_pkg::RSC_RESP_OKAY);
      rampClockPin <= 1'b0;
      $display("test trigger A advance done");
   endtask

   task automatic test_repeat_trigger_b;
      int c0;
      c0 = calCount;
      // delay count 2 scaled by 8, calibration after every ramp, repeat second ramp on trigger B
      wreg(rsc_pkg::RSC_IDX_SCALE, 16'h0013, rsc_pkg::RSC_RESP_OKAY);
      wreg(rsc_pkg::RSC_IDX_SEQ, 16'h00b2, rsc_pkg::RSC_RESP_OKAY);
      chk({31'h0, manualMode}, 32'h0000_0001);
      // trigger A always fires, trigger B on direction pin falling edge
      wreg(rsc_pkg::RSC_IDX_TRIG, 16'h0520, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_TRIG, 32'h0000_0520, rsc_pkg::RSC_RESP_OKAY);
      rampDirectionPin <= 1'b1;
      wreg(rsc_pkg::RSC_IDX_CTRL, 16'h0001, rsc_pkg::RSC_RESP_OKAY);
      wait_state(rsc_pkg::RSC_CAL);
      repeat (16) @(posedge clk);
      #1 chk({30'h0, rampState}, {30'h0, rsc_pkg::RSC_CAL});
      @(posedge clk);
      #1 chk({30'h0, rampState}, {30'h0, rsc_pkg::RSC_SECOND});
      repeat (3) @(posedge clk);
      #1 chk({30'h0, rampState}, {30'h0, rsc_pkg::RSC_SECOND});
      @(posedge clk) rampDirectionPin <= 1'b0;
      wait_state(rsc_pkg::RSC_CAL);
      wait_state(rsc_pkg::RSC_SECOND);
      wreg(rsc_pkg::RSC_IDX_SEQ, 16'h00b3, rsc_pkg::RSC_RESP_OKAY);
      repeat (5) @(posedge clk);
      #1 chk({30'h0, rampState}, {30'h0, rsc_pkg::RSC_SECOND});
      chk(calCount, c0 + 2);
      @(posedge clk) tuneLockStatus <= 2'h3;
      wreg(rsc_pkg::RSC_IDX_CTRL, 16'h0000, rsc_pkg::RSC_RESP_OKAY);
      rreg(rsc_pkg::RSC_IDX_LOCK, 32'h0000_0660, rsc_pkg::RSC_RESP_OKAY);
      $display("test repeat and trigger B done");
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      rst = 1'b1;
      rampClockPin = 1'b0;
      rampDirectionPin = 1'b0;
      tuneLockStatus = 2'h0;
      calResult = '{core: 3'h3, cap: 8'h5a, amp: 9'h123};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      test_reset_and_ro();
      tuneLockStatus <= 2'h2;
      test_cal_after_ramp();
      test_trigger_a();
      test_repeat_trigger_b();
      conclude();
   end

   initial begin
      #2_000_000;
      bad_count++;
      conclude();
   end
endmodule
